// [verilog/lcdhp_defines.svh]
// offsets, field positions, reset values and sizes of the lcd host port
`ifndef LCDHP_DEFINES_SVH
`define LCDHP_DEFINES_SVH
`define LCDHP_CTRL_OFF    8'h00
`define LCDHP_STATUS_OFF  8'h04
`define LCDHP_VIEW_OFF    8'h08
`define LCDHP_COUNT_OFF   8'h0c
`define LCDHP_CTRL_RST    1'b0
`define LCDHP_WIDTH8_RST  1'b1
`define LCDHP_ST_W8       0
`define LCDHP_ST_LINES    1
`define LCDHP_ST_FONT     2
`define LCDHP_ST_ADDR     8
`define LCDHP_ST_SHIFT    16
`define LCDHP_ST_LAST     24
`define LCDHP_VW_ROW      0
`define LCDHP_VW_COL      8
`define LCDHP_VW_ADDR     16
`define LCDHP_VW_CHAR     24
`define LCDHP_COLS16      7'h10
`define LCDHP_COLS20      7'h14
`define LCDHP_LEN16       7'h20
`define LCDHP_LEN20       7'h28
`define LCDHP_LINE2_BASE  7'h40
`define LCDHP_RESP_OKAY   2'h0
`define LCDHP_RESP_SLVERR 2'h2
`endif

// [verilog/lcdhp_pkg.sv]
// types shared by the lcd host port
package lcdhp_pkg;
    typedef struct packed {
        logic       reg_select;
        logic       read_write;
        logic       strobe;
        logic [7:0] parallel_bus_lines;
    } lcdhp_pins_t;
    typedef struct packed {
        logic [1:0] row;
        logic [4:0] col;
    } lcdhp_view_t;
endpackage : lcdhp_pkg

// [verilog/lcdhp_mem.sv]
// display data memory, one write port and two registered read ports
`timescale 1ns/10ps
module lcdhp_mem #(
    parameter int DW = 8,
    parameter int AW = 7
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read ports
    input  wire logic [AW-1:0] a_addr,
    output logic      [DW-1:0] a_data,
    input  wire logic [AW-1:0] b_addr,
    output logic      [DW-1:0] b_data
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_data <= '0;
            b_data <= '0;
        end else begin
            a_data <= mem_q[a_addr];
            b_data <= mem_q[b_addr];
        end
    end
endmodule : lcdhp_mem

// [verilog/lcdhp_top.sv]
// lcd module host port with display memory and axi4-lite register slave
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "lcdhp_defines.svh"
module lcdhp_top #(
    parameter int AXI_AW = 8
) (
    // system
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // host pins
    input  wire lcdhp_pkg::lcdhp_pins_t pins_i,
    output logic      [7:0]           bus_o,
    output logic      [7:0]           bus_oe,
    // axi4-lite write
    input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic      [1:0]           s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [AXI_AW-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic      [31:0]          s_axi_rdata,
    output logic      [1:0]           s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    import lcdhp_pkg::*;

    if (AXI_AW < 4 || AXI_AW > 8) begin : g_chk
        $error("AXI_AW must lie between 4 and 8");
    end

    lcdhp_pins_t s1_q, s2_q;
    lcdhp_view_t view_q;
    logic        en_prev_q, width8_q, lines_q, font_q, nib_q, cols20_q;
    logic [3:0]  hi_q;
    logic [6:0]  addr_q;
    logic [5:0]  shift_q;
    logic [7:0]  last_q, mem_a, mem_b;
    logic [15:0] cnt_q;
    logic        fall, cpl, instr, data_wr, data_rd, ctrl_wr;
    logic        is_addr, is_func, is_shift;
    logic [7:0]  wbyte, rdbyte;
    logic [6:0]  cols, len, colc, pos, sp, vaddr, addr_nx, addr_pv;

    // pins cross two flops before anything looks at them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q      <= '0;
            s2_q      <= '0;
            en_prev_q <= 1'b0;
        end else begin
            s1_q      <= pins_i;
            s2_q      <= s1_q;
            en_prev_q <= s2_q.strobe;
        end
    end

    // transfers are qualified by the falling strobe
    assign fall    = en_prev_q & ~s2_q.strobe;
    assign cpl     = fall & (width8_q | nib_q);
    assign wbyte   = width8_q ? s2_q.parallel_bus_lines
                              : {hi_q, s2_q.parallel_bus_lines[7:4]};
    assign instr   = cpl & ~s2_q.read_write & ~s2_q.reg_select;
    assign data_wr = cpl & ~s2_q.read_write & s2_q.reg_select;
    assign data_rd = cpl & s2_q.read_write & s2_q.reg_select;
    assign is_addr  = wbyte[7];
    assign is_func  = wbyte[7:5] == 3'h1;
    assign is_shift = wbyte[7:4] == 4'h1;
    // busy flag always reads zero: every instruction finishes in one cycle
    assign rdbyte  = s2_q.reg_select ? mem_a : {1'b0, addr_q};

    // four lines are two controller lines of 32 or 40 characters
    assign cols = cols20_q ? `LCDHP_COLS20 : `LCDHP_COLS16;
    assign len  = cols20_q ? `LCDHP_LEN20 : `LCDHP_LEN16;
    assign addr_nx = (addr_q == len - 7'h01) ? `LCDHP_LINE2_BASE :
                     (addr_q == `LCDHP_LINE2_BASE + len - 7'h01) ? 7'h00 : addr_q + 7'h01;
    assign addr_pv = (addr_q == 7'h00) ? `LCDHP_LINE2_BASE + len - 7'h01 :
                     (addr_q == `LCDHP_LINE2_BASE) ? len - 7'h01 : addr_q - 7'h01;

    // visible position to memory address, lines three and four continue one and two
    always_comb begin
        colc  = ({2'b00, view_q.col} >= cols) ? cols - 7'h01 : {2'b00, view_q.col};
        pos   = (view_q.row[1] ? cols : 7'h00) + colc;
        sp    = pos + {1'b0, shift_q};
        if (sp >= len) begin
            sp = sp - len;
        end
        vaddr = (view_q.row[0] ? `LCDHP_LINE2_BASE : 7'h00) + sp;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 7'h00;
        end else if (instr && is_addr) begin
            addr_q <= wbyte[6:0];
        end else if (data_wr || data_rd || (instr && is_shift && wbyte[3:2] == 2'b01)) begin
            addr_q <= addr_nx;
        end else if (instr && is_shift && wbyte[3:2] == 2'b00) begin
            addr_q <= addr_pv;
        end
    end

    // function set picks bus width, line count and font
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            width8_q <= `LCDHP_WIDTH8_RST;
            lines_q  <= 1'b0;
            font_q   <= 1'b0;
        end else if (instr && is_func) begin
            width8_q <= wbyte[4];
            lines_q  <= wbyte[3];
            font_q   <= wbyte[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nib_q <= 1'b0;
            hi_q  <= 4'h0;
        end else if (fall && !width8_q) begin
            nib_q <= ~nib_q;
            if (!nib_q && !s2_q.read_write) begin
                hi_q <= s2_q.parallel_bus_lines[7:4];
            end
        end
    end

    // a column change would leave the offset outside the shorter row
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 6'h00;
        end else if (ctrl_wr) begin
            shift_q <= 6'h00;
        end else if (instr && is_shift && wbyte[3]) begin
            if (wbyte[2]) begin
                shift_q <= (shift_q == 6'h00) ? 6'(len - 7'h01) : shift_q - 6'h01;
            end else begin
                shift_q <= ({1'b0, shift_q} == len - 7'h01) ? 6'h00 : shift_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= 8'h00;
            cnt_q  <= 16'h0000;
        end else if (cpl) begin
            last_q <= s2_q.read_write ? rdbyte : wbyte;
            cnt_q  <= cnt_q + 16'h0001;
        end
    end

    // module drives the lines only while read/write and strobe are high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_o  <= 8'h00;
            bus_oe <= 8'h00;
        end else begin
            bus_o  <= width8_q ? rdbyte : {nib_q ? rdbyte[3:0] : rdbyte[7:4], 4'h0};
            if (s2_q.read_write && s2_q.strobe) begin
                bus_oe <= width8_q ? 8'hff : 8'hf0;
            end else begin
                bus_oe <= 8'h00;
            end
        end
    end

    lcdhp_mem #(.DW(8), .AW(7)) i_lcdhp_mem (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (data_wr),
        .wr_addr (addr_q),
        .wr_data (wbyte),
        .a_addr  (addr_q),
        .a_data  (mem_a),
        .b_addr  (vaddr),
        .b_data  (mem_b)
    );

    // axi4-lite write side: address and data taken in either order
    logic              aw_have_q, w_have_q, do_wr;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    assign do_wr   = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign ctrl_wr = do_wr && awaddr_q == AXI_AW'(`LCDHP_CTRL_OFF) && wstrb_q[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LCDHP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q[1:0] == 2'b00 && awaddr_q <= AXI_AW'(`LCDHP_COUNT_OFF))
                                ? `LCDHP_RESP_OKAY : `LCDHP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cols20_q <= `LCDHP_CTRL_RST;
            view_q   <= '0;
        end else if (do_wr && awaddr_q == AXI_AW'(`LCDHP_CTRL_OFF)) begin
            if (wstrb_q[0]) begin
                cols20_q <= wdata_q[0];
            end
        end else if (do_wr && awaddr_q == AXI_AW'(`LCDHP_VIEW_OFF)) begin
            if (wstrb_q[0]) begin
                view_q.row <= wdata_q[`LCDHP_VW_ROW +: 2];
            end
            if (wstrb_q[1]) begin
                view_q.col <= wdata_q[`LCDHP_VW_COL +: 5];
            end
        end
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LCDHP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `LCDHP_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            case (s_axi_araddr)
                AXI_AW'(`LCDHP_CTRL_OFF): s_axi_rdata[0] <= cols20_q;
                AXI_AW'(`LCDHP_STATUS_OFF): begin
                    s_axi_rdata[`LCDHP_ST_W8]       <= width8_q;
                    s_axi_rdata[`LCDHP_ST_LINES]    <= lines_q;
                    s_axi_rdata[`LCDHP_ST_FONT]     <= font_q;
                    s_axi_rdata[`LCDHP_ST_ADDR +: 7]  <= addr_q;
                    s_axi_rdata[`LCDHP_ST_SHIFT +: 6] <= shift_q;
                    s_axi_rdata[`LCDHP_ST_LAST +: 8]  <= last_q;
                end
                AXI_AW'(`LCDHP_VIEW_OFF): begin
                    s_axi_rdata[`LCDHP_VW_ROW +: 2]  <= view_q.row;
                    s_axi_rdata[`LCDHP_VW_COL +: 5]  <= view_q.col;
                    s_axi_rdata[`LCDHP_VW_ADDR +: 7] <= vaddr;
                    s_axi_rdata[`LCDHP_VW_CHAR +: 8] <= mem_b;
                end
                AXI_AW'(`LCDHP_COUNT_OFF): s_axi_rdata[15:0] <= cnt_q;
                default: s_axi_rresp <= `LCDHP_RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    lower_lines_a: assert property (!width8_q |-> bus_oe[3:0] == 4'h0)
        else $error("lower lines driven in 4-bit mode");
    nibble_pair_a: assert property (fall && !width8_q && !nib_q |-> !cpl ##1 nib_q)
        else $error("byte completed on first nibble");
    high_first_a: assert property (fall && !width8_q && !nib_q && !s2_q.read_write
        |=> hi_q == $past(s2_q.parallel_bus_lines[7:4]))
        else $error("high nibble not captured first");
    full_byte_a: assert property (fall && width8_q |-> cpl && wbyte == s2_q.parallel_bus_lines)
        else $error("8-bit byte not taken in one transfer");
    view_range_a: assert property (vaddr < len ||
        (vaddr >= `LCDHP_LINE2_BASE && vaddr < `LCDHP_LINE2_BASE + len))
        else $error("visible address outside range");
    shift_bound_a: assert property ({1'b0, shift_q} < len)
        else $error("shift offset beyond line length");
    shift_left_a: assert property (instr && is_shift && wbyte[3:2] == 2'b10 && !ctrl_wr
        |=> shift_q == (($past(shift_q) == 6'(len - 7'h01)) ? 6'h00 : $past(shift_q) + 6'h01))
        else $error("display shift left wrong");
    addr_set_a: assert property (instr && is_addr |=> addr_q == $past(wbyte[6:0]))
        else $error("address set not applied");
    read_drive_a: assert property (bus_oe != 8'h00 |-> $past(s2_q.read_write && s2_q.strobe))
        else $error("bus driven outside a read");
    line_start_a: assert property (view_q.row == 2'd2 && view_q.col == 5'd0 && shift_q == 6'h00
        |-> vaddr == cols)
        else $error("third line start wrong");

    nib_write_c: cover property (data_wr && !width8_q);
    byte_read_c: cover property (data_rd && width8_q);
    disp_shift_c: cover property (instr && is_shift && wbyte[3]);
    view_read_c: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == AXI_AW'(`LCDHP_VIEW_OFF));
endmodule : lcdhp_top

// [verif/lcdhp_host_model.sv]
// host processor model on the lcd module's parallel pins
`timescale 1ns/10ps
module lcdhp_host_model (
    // system
    input  wire logic              clk,
    // lcd pins
    output lcdhp_pkg::lcdhp_pins_t pins_o,
    input  wire logic [7:0]        bus_o,
    input  wire logic [7:0]        bus_oe
);
    import lcdhp_pkg::*;
    logic       wide_q = 1'b1;
    logic       rs_q   = 1'b0;
    logic       rw_q   = 1'b0;
    logic       stb_q  = 1'b0;
    logic [7:0] drv_q  = 8'h00;
    logic [7:0] dat_q  = 8'h00;
    logic [7:0] oe_seen;
    // a released line shows the inverse of its last value, so stale data never passes
    always_comb begin
        pins_o.reg_select = rs_q;
        pins_o.read_write = rw_q;
        pins_o.strobe     = stb_q;
        for (int i = 0; i < 8; i++) begin
            pins_o.parallel_bus_lines[i] = bus_oe[i] ? bus_o[i] :
                (drv_q[i] ? dat_q[i] : ~dat_q[i]);
        end
    end
    // long strobe and hold because the pins pass two sync flops inside
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        input logic [7:0] lanes, output logic [7:0] seen);
        @(posedge clk);
        rs_q  <= rs;
        rw_q  <= rw;
        dat_q <= d;
        drv_q <= rw ? 8'h00 : lanes;
        stb_q <= 1'b1;
        repeat (6) @(posedge clk);
        seen    = pins_o.parallel_bus_lines;
        oe_seen = bus_oe;
        stb_q <= 1'b0;
        repeat (4) @(posedge clk);
        drv_q <= 8'h00;
        rw_q  <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : xfer
    task automatic put_byte(input logic rs, input logic [7:0] b);
        logic [7:0] s;
        if (wide_q) begin
            xfer(rs, 1'b0, b, 8'hff, s);
        end else begin
            xfer(rs, 1'b0, {b[7:4], 4'h0}, 8'hf0, s);
            xfer(rs, 1'b0, {b[3:0], 4'h0}, 8'hf0, s);
        end
    endtask : put_byte
    task automatic get_byte(input logic rs, output logic [7:0] b);
        logic [7:0] hi;
        logic [7:0] lo;
        if (wide_q) begin
            xfer(rs, 1'b1, 8'h00, 8'h00, b);
        end else begin
            xfer(rs, 1'b1, 8'h00, 8'h00, hi);
            xfer(rs, 1'b1, 8'h00, 8'h00, lo);
            b = {hi[7:4], lo[7:4]};
        end
    endtask : get_byte
    task automatic set_wide(input logic w);
        wide_q = w;
    endtask : set_wide
endmodule : lcdhp_host_model

// [verif/test_char_lcd_module_host_port.sv]
// self-checking bench for the lcd host port
`timescale 1ns/10ps
`include "lcdhp_defines.svh"
`define LCDHP_HOST i_lcdhp_host_model
`define LCDHP_CHECK(nm, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module test_char_lcd_module_host_port;
    import lcdhp_pkg::*;
    int               miscompares = 0;
    int               checks_done = 0;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic [7:0]       awaddr = 8'h00;
    logic [7:0]       araddr = 8'h00;
    logic [31:0]      wdata = 32'h0;
    logic [3:0]       wstrb = 4'hf;
    logic             awvalid = 1'b0;
    logic             wvalid = 1'b0;
    logic             bready = 1'b0;
    logic             arvalid = 1'b0;
    logic             rready = 1'b0;
    wire logic        awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  bus_o, bus_oe;
    wire lcdhp_pins_t pins;
    logic [31:0]      rd;
    logic [1:0]       resp;
    logic [7:0]       b;
    always #4 clk = ~clk;
    lcdhp_top i_lcdhp_top (
        .clk(clk), .rst_n(rst_n), .pins_i(pins), .bus_o(bus_o), .bus_oe(bus_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    lcdhp_host_model i_lcdhp_host_model (
        .clk(clk), .pins_o(pins), .bus_o(bus_o), .bus_oe(bus_oe)
    );
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd   = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    // character lags the address by a cycle, hence the wait
    task automatic view(input logic [1:0] row, input logic [4:0] col);
        axi_wr(`LCDHP_VIEW_OFF, {19'h0, col, 6'h0, row});
        repeat (2) @(posedge clk);
        axi_rd(`LCDHP_VIEW_OFF);
    endtask : view
    task automatic t_regs();
        axi_rd(`LCDHP_CTRL_OFF);
        `LCDHP_CHECK("ctrl reset", `LCDHP_CTRL_RST, rd[0])
        axi_rd(`LCDHP_STATUS_OFF);
        `LCDHP_CHECK("width reset", `LCDHP_WIDTH8_RST, rd[`LCDHP_ST_W8])
        axi_rd(8'h10);
        `LCDHP_CHECK("unmapped rresp", `LCDHP_RESP_SLVERR, resp)
        `LCDHP_CHECK("unmapped rdata", 32'h0, rd)
        axi_wr(8'h01, 32'h1);
        `LCDHP_CHECK("unaligned bresp", `LCDHP_RESP_SLVERR, resp)
        axi_wr(`LCDHP_STATUS_OFF, 32'h0);
        `LCDHP_CHECK("ro bresp", `LCDHP_RESP_OKAY, resp)
        axi_rd(`LCDHP_CTRL_OFF);
        `LCDHP_CHECK("ctrl kept", 1'b0, rd[0])
        $display("done regs");
    endtask : t_regs
    task automatic t_wide();
        `LCDHP_HOST.put_byte(1'b0, 8'h38);
        axi_rd(`LCDHP_STATUS_OFF);
        `LCDHP_CHECK("w8 n f", 3'b011, rd[2:0])
        `LCDHP_HOST.put_byte(1'b0, 8'h85);
        `LCDHP_HOST.put_byte(1'b1, 8'h41);
        `LCDHP_HOST.put_byte(1'b1, 8'hc6);
        `LCDHP_HOST.get_byte(1'b0, b);
        `LCDHP_CHECK("addr read", 8'h07, b)
        `LCDHP_CHECK("oe 8 bit", 8'hff, `LCDHP_HOST.oe_seen)
        `LCDHP_HOST.put_byte(1'b0, 8'h85);
        `LCDHP_HOST.get_byte(1'b1, b);
        `LCDHP_CHECK("data one", 8'h41, b)
        `LCDHP_HOST.get_byte(1'b1, b);
        `LCDHP_CHECK("data two", 8'hc6, b)
        $display("done wide");
    endtask : t_wide
    task automatic t_nib();
        logic [15:0] cnt;
        `LCDHP_HOST.put_byte(1'b0, 8'h28);
        `LCDHP_HOST.set_wide(1'b0);
        axi_rd(`LCDHP_COUNT_OFF);
        cnt = rd[15:0];
        `LCDHP_HOST.xfer(1'b0, 1'b0, 8'hc0, 8'hf0, b);
        axi_rd(`LCDHP_COUNT_OFF);
        `LCDHP_CHECK("half byte", cnt, rd[15:0])
        `LCDHP_HOST.xfer(1'b0, 1'b0, 8'h30, 8'hf0, b);
        axi_rd(`LCDHP_STATUS_OFF);
        `LCDHP_CHECK("nib addr", 7'h43, rd[14:8])
        `LCDHP_CHECK("w4 n f", 3'b010, rd[2:0])
        axi_rd(`LCDHP_COUNT_OFF);
        `LCDHP_CHECK("full byte", cnt + 16'h1, rd[15:0])
        `LCDHP_HOST.put_byte(1'b1, 8'h5a);
        `LCDHP_HOST.put_byte(1'b0, 8'hc3);
        `LCDHP_HOST.get_byte(1'b1, b);
        `LCDHP_CHECK("nib data", 8'h5a, b)
        `LCDHP_CHECK("oe 4 bit", 8'hf0, `LCDHP_HOST.oe_seen)
        view(2'd1, 5'd3);
        `LCDHP_CHECK("view char", 8'h5a, rd[31:24])
        `LCDHP_HOST.put_byte(1'b0, 8'h38);
        `LCDHP_HOST.set_wide(1'b1);
        axi_rd(`LCDHP_STATUS_OFF);
        `LCDHP_CHECK("back to 8", 1'b1, rd[0])
        $display("done nibble");
    endtask : t_nib
    task automatic t_lines();
        logic [6:0] base [8] = '{7'h00, 7'h40, 7'h10, 7'h50, 7'h00, 7'h40, 7'h14, 7'h54};
        for (int m = 0; m < 2; m++) begin
            axi_wr(`LCDHP_CTRL_OFF, 32'(m));
            for (int r = 0; r < 4; r++) begin
                view(2'(r), 5'h00);
                `LCDHP_CHECK("line start", base[m*4+r], rd[22:16])
                view(2'(r), 5'h1f);
                `LCDHP_CHECK("line end", base[m*4+r] + (m ? 7'h13 : 7'h0f), rd[22:16])
            end
        end
        $display("done lines");
    endtask : t_lines
    task automatic t_shift();
        axi_wr(`LCDHP_CTRL_OFF, 32'h0);
        `LCDHP_HOST.put_byte(1'b0, 8'h90);
        `LCDHP_HOST.put_byte(1'b1, 8'h33);
        `LCDHP_HOST.put_byte(1'b0, 8'h18);
        axi_rd(`LCDHP_STATUS_OFF);
        `LCDHP_CHECK("shift left", 6'h01, rd[21:16])
        view(2'd0, 5'd15);
        `LCDHP_CHECK("third to first", 7'h10, rd[22:16])
        `LCDHP_CHECK("moved char", 8'h33, rd[31:24])
        view(2'd2, 5'd15);
        `LCDHP_CHECK("first to third", 7'h00, rd[22:16])
        view(2'd3, 5'd15);
        `LCDHP_CHECK("second to fourth", 7'h40, rd[22:16])
        `LCDHP_HOST.put_byte(1'b0, 8'h1c);
        view(2'd0, 5'd15);
        `LCDHP_CHECK("shift right", 7'h0f, rd[22:16])
        `LCDHP_HOST.put_byte(1'b0, 8'h9f);
        `LCDHP_HOST.put_byte(1'b0, 8'h14);
        axi_rd(`LCDHP_STATUS_OFF);
        `LCDHP_CHECK("cursor wrap up", 7'h40, rd[14:8])
        `LCDHP_HOST.put_byte(1'b0, 8'h10);
        axi_rd(`LCDHP_STATUS_OFF);
        `LCDHP_CHECK("cursor wrap down", 7'h1f, rd[14:8])
        $display("done shift");
    endtask : t_shift
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_wide();
        t_nib();
        t_lines();
        t_shift();
        complete_run();
    end
    // whole run needs under a thousand cycles; this leaves ample margin
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule : test_char_lcd_module_host_port
